//--- tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// register byte offsets
`define TCC_DIAL_OFF 8'h00
`define TCC_STATUS_OFF 8'h04
`define TCC_IRQ_STAT_OFF 8'h08
`define TCC_IRQ_MASK_OFF 8'h0c

// interrupt and status field positions
`define TCC_EV_PTD 0
`define TCC_EV_CONNECTED_INDICATOR 1
`define TCC_EV_IDLE 2
`define TCC_EV_RING 3
`define TCC_EV_DIAL_DONE 4
`define TCC_EV_W 5
`define TCC_ST_DIAL_BUSY 7
`define TCC_ST_MOTOR 8

// reset values and pulse count for digit 0
`define TCC_IRQ_MASK_RST 5'h00
`define TCC_DIAL_TEN 4'ha

// timebase
`define TCC_CLK_PERIOD_NS 100
`define TCC_TICK_NS 1000000

// intervals in ms
`define TCC_PTD_FILTER_MS 1
`define TCC_CONNECTED_INDICATOR_FILTER_MS 20
`define TCC_DIAL_BREAK_MS 60
`define TCC_DIAL_MAKE_MS 40
`define TCC_DIAL_CONTACT_MS 6
`define TCC_BUZZ_MS 2600
`define TCC_MOTOR_OFF_MS 575

`endif

//--- tcc_exchange.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_exchange
	import tcc_pkg::*;
(
	// clock
	input wire logic ref_clk_i,
	// command: 0 open, 1 positive, 2 negative
	input wire logic [1:0] cmd_i,
	// station loop drive
	input wire logic shunt_i,
	input wire logic open_i,
	// loop as seen by the station
	output line_type line_o
);
	// idle current too weak to mark; only a shunted, closed loop marks
	always @(posedge ref_clk_i)
	begin
		line_o.pos <= (cmd_i == 2'h1);
		line_o.neg <= (cmd_i == 2'h2);
		line_o.mark <= (cmd_i != 2'h0) && shunt_i && !open_i;
	end
endmodule
`default_nettype wire

//--- tcc_pkg.sv
`default_nettype none
package tcc_pkg;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_ORIGINATE = 7'h02,
		ST_DIALING = 7'h04,
		ST_CONNECTED = 7'h08,
		ST_DISCONNECT = 7'h10,
		ST_LOCAL = 7'h20,
		ST_RINGING = 7'h40
	} state_type;

	typedef struct packed
	{
		logic pos;
		logic neg;
		logic mark;
	} line_type;

	typedef struct packed
	{
		logic originate;
		logic hangup_button_alt;
		logic offline_button_alt;
	} buttons_type;

endpackage
`default_nettype wire

//--- telegraph_call_control.sv
// Notes on behaviour
// RQ1: ten pulses per second, contact briefly open
// RQ2: selector held marking while dial off rest
// RQ3: idle keeps motor and indicators off; motor stays on for MOTOR_MS ms after idle is entered
// RQ4: originate button applies loop shunt
// RQ5: line interruption lights dial lamp, latches shunt
// RQ6: pulse is 60 ms open, 40 ms mark
// RQ7: reversal to negative starts motor, connected lamp
// RQ8: connected traffic marks with current, spaces without
// RQ9: busy reversal then positive returns to idle
// RQ10: incoming reversal connects with shunt and motor
// RQ11: stop opens line until positive returns
// RQ12: remote disconnect returns idle the same way
// RQ13: local button, stop exits, originate calls
// RQ14: call in local buzzes 2.6 s then connects
// RQ15: filtered latches, 1 ms and 20 ms delays
// RQ16: selector follows line above half mark level
// RQ17: motor turn-off delayed 0.475 to 0.675 s
// RQ18: sampled inputs, intervals counted from ms tick
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.svh"

module telegraph_call_control
	import tcc_pkg::*;
#(
	parameter int TICK_CYC = `TCC_TICK_NS / `TCC_CLK_PERIOD_NS,
	parameter int PTD_MS = `TCC_PTD_FILTER_MS,
	parameter int CONNECTED_INDICATOR_MS = `TCC_CONNECTED_INDICATOR_FILTER_MS,
	parameter int BREAK_MS = `TCC_DIAL_BREAK_MS,
	parameter int MAKE_MS = `TCC_DIAL_MAKE_MS,
	parameter int CONTACT_MS = `TCC_DIAL_CONTACT_MS,
	parameter int BUZZ_MS = `TCC_BUZZ_MS,
	parameter int MOTOR_MS = `TCC_MOTOR_OFF_MS
)
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// loop line and operator controls
	input wire line_type line_i,
	input wire buttons_type buttons_i,
	input wire logic dial_offnormal_i,
	// loop drive
	output logic loop_shunt_o,
	output logic loop_open_o,
	output logic dial_contact_o,
	// indicators and set drive
	output logic dial_lamp_o,
	output logic connected_indicator_o,
	output logic local_lamp_o,
	output logic buzzer_o,
	output logic motor_o,
	output logic selector_driver_o,
	// interrupt
	output logic irq_o
);

	if (TICK_CYC < 2 || TICK_CYC > 65535 || PTD_MS < 1 || CONNECTED_INDICATOR_MS > 255 || PTD_MS > 255
		|| BREAK_MS < 1 || BREAK_MS > 255 || MAKE_MS < 1 || MAKE_MS > 255
		|| CONTACT_MS > BREAK_MS || BUZZ_MS > 4095 || MOTOR_MS > 4095)
	begin : g_bad
		$error("telegraph_call_control: parameter out of range");
	end

	state_type state_q;
	state_type state_d;
	logic [15:0] tick_cnt_q;
	logic tick_q;
	logic [2:0] cond;
	logic [7:0] filt_q [3];
	logic ptd_seen;
	logic neg_seen;
	logic pos_seen;
	logic [11:0] buzz_ms_q;
	logic motor_req;
	logic [11:0] off_ms_q;
	logic [3:0] dial_left_q;
	logic dial_make_q;
	logic [7:0] dial_ms_q;
	logic dial_busy;
	logic dial_done;
	logic apb_req;
	logic wr_fire;
	logic dial_wr;
	logic [`TCC_EV_W-1:0] ev;
	logic [`TCC_EV_W-1:0] irq_stat_q;
	logic [`TCC_EV_W-1:0] irq_mask_q;
	logic [31:0] rd_mux;
	logic rd_hit;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	// 1 ms timebase
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == 16'(TICK_CYC - 1))
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1; // RQ18
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// line noise filters: 0 open, 1 negative, 2 positive
	assign cond = {line_i.pos & ~line_i.neg, line_i.neg & ~line_i.pos, ~line_i.pos & ~line_i.neg};

	for (genvar g = 0; g < 3; g++)
	begin : g_filt
		always_ff @(posedge ref_clk_i or posedge rst_i)
		begin
			if (rst_i)
				filt_q[g] <= 8'h00;
			else if (!cond[g])
				filt_q[g] <= 8'h00;
			else if (tick_q && filt_q[g] != 8'hff)
				filt_q[g] <= filt_q[g] + 8'h01; // RQ15 RQ18
		end
	end

	assign ptd_seen = filt_q[0] >= 8'(PTD_MS);
	assign neg_seen = filt_q[1] >= 8'(CONNECTED_INDICATOR_MS);
	assign pos_seen = filt_q[2] >= 8'(CONNECTED_INDICATOR_MS);

	// call sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (neg_seen)
					state_d = ST_CONNECTED; // RQ10
				else if (buttons_i.originate)
					state_d = ST_ORIGINATE; // RQ4
				else if (buttons_i.offline_button_alt)
					state_d = ST_LOCAL; // RQ13
			end
			ST_ORIGINATE:
			begin
				if (ptd_seen)
					state_d = ST_DIALING; // RQ5
				else if (!buttons_i.originate)
					state_d = ST_IDLE; // RQ4
			end
			ST_DIALING:
			begin
				if (neg_seen)
					state_d = ST_CONNECTED; // RQ7
				else if (buttons_i.hangup_button_alt)
					state_d = ST_IDLE;
			end
			ST_CONNECTED:
			begin
				if (pos_seen)
					state_d = ST_IDLE; // RQ9 RQ12
				else if (buttons_i.hangup_button_alt)
					state_d = ST_DISCONNECT; // RQ11
			end
			ST_DISCONNECT:
			begin
				if (pos_seen)
					state_d = ST_IDLE; // RQ11
			end
			ST_LOCAL:
			begin
				if (neg_seen)
					state_d = ST_RINGING; // RQ14
				else if (buttons_i.hangup_button_alt)
					state_d = ST_IDLE; // RQ13
				else if (buttons_i.originate)
					state_d = ST_ORIGINATE; // RQ13
			end
			ST_RINGING:
			begin
				if (buzz_ms_q == 12'(BUZZ_MS))
					state_d = ST_CONNECTED; // RQ14
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// buzzer interval
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			buzz_ms_q <= 12'h000;
		else if (state_q != ST_RINGING)
			buzz_ms_q <= 12'h000;
		else if (tick_q)
			buzz_ms_q <= buzz_ms_q + 12'h001; // RQ14
	end

	// motor with turn-off delay; lets the printing cycle finish
	assign motor_req = state_d inside {ST_CONNECTED, ST_DISCONNECT, ST_LOCAL, ST_RINGING};

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			off_ms_q <= 12'h000;
			motor_o <= 1'b0;
		end
		else if (motor_req)
		begin
			off_ms_q <= 12'h000;
			motor_o <= 1'b1; // RQ7
		end
		else
		begin
			if (motor_o && tick_q)
				off_ms_q <= off_ms_q + 12'h001;
			motor_o <= motor_o && off_ms_q != 12'(MOTOR_MS); // RQ17 RQ3
		end
	end

	// dial pulse generator, digit written by software
	assign dial_busy = dial_left_q != 4'h0;
	assign dial_wr = wr_fire && paddr_i == `TCC_DIAL_OFF && !dial_busy
		&& state_q inside {ST_DIALING, ST_CONNECTED} && pwdata_i[3:0] <= `TCC_DIAL_TEN;
	assign dial_done = dial_busy && dial_make_q && tick_q && dial_ms_q == 8'(MAKE_MS - 1)
		&& dial_left_q == 4'h1;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dial_left_q <= 4'h0;
			dial_make_q <= 1'b0;
			dial_ms_q <= 8'h00;
		end
		else if (dial_wr)
		begin
			dial_left_q <= pwdata_i[3:0] == 4'h0 ? `TCC_DIAL_TEN : pwdata_i[3:0];
			dial_make_q <= 1'b0;
			dial_ms_q <= 8'h00;
		end
		else if (!(state_q inside {ST_DIALING, ST_CONNECTED}))
			dial_left_q <= 4'h0; // call dropped mid digit
		else if (dial_busy && tick_q)
		begin
			if (!dial_make_q && dial_ms_q == 8'(BREAK_MS - 1))
			begin
				dial_make_q <= 1'b1; // RQ6
				dial_ms_q <= 8'h00;
			end
			else if (dial_make_q && dial_ms_q == 8'(MAKE_MS - 1))
			begin
				dial_make_q <= 1'b0; // RQ1 RQ6
				dial_ms_q <= 8'h00;
				dial_left_q <= dial_left_q - 4'h1;
			end
			else
				dial_ms_q <= dial_ms_q + 8'h01;
		end
	end

	// line and indicator drive
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			loop_shunt_o <= 1'b0;
			loop_open_o <= 1'b0;
			dial_contact_o <= 1'b0;
			dial_lamp_o <= 1'b0;
			connected_indicator_o <= 1'b0;
			local_lamp_o <= 1'b0;
			buzzer_o <= 1'b0;
		end
		else
		begin
			loop_shunt_o <= state_d inside {ST_ORIGINATE, ST_DIALING, ST_CONNECTED}; // RQ4 RQ5 RQ8 RQ10
			loop_open_o <= state_d == ST_DISCONNECT || (dial_busy && !dial_make_q); // RQ6 RQ11
			dial_contact_o <= dial_busy && !dial_make_q && dial_ms_q < 8'(CONTACT_MS); // RQ1
			dial_lamp_o <= state_d == ST_DIALING; // RQ5
			connected_indicator_o <= state_d inside {ST_CONNECTED, ST_DISCONNECT}; // RQ7 RQ9
			local_lamp_o <= state_d == ST_LOCAL; // RQ13
			buzzer_o <= state_d == ST_RINGING; // RQ14
		end
	end

	// amplifying relay, blinded while dialing
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			selector_driver_o <= 1'b1;
		else
			selector_driver_o <= dial_offnormal_i || dial_busy || line_i.mark; // RQ2 RQ16 RQ8
	end

	// apb slave: one wait state, write lands on the pready edge
	assign apb_req = psel_i && penable_i && !pready_o;
	assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;

	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			`TCC_DIAL_OFF:
				rd_mux[3:0] = dial_left_q;
			`TCC_STATUS_OFF:
			begin
				rd_mux[6:0] = state_q;
				rd_mux[`TCC_ST_DIAL_BUSY] = dial_busy;
				rd_mux[`TCC_ST_MOTOR] = motor_o;
			end
			`TCC_IRQ_STAT_OFF:
				rd_mux[`TCC_EV_W-1:0] = irq_stat_q;
			`TCC_IRQ_MASK_OFF:
				rd_mux[`TCC_EV_W-1:0] = irq_mask_q;
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end
		else
		begin
			pready_o <= apb_req;
			pslverr_o <= apb_req && !rd_hit;
			prdata_o <= (apb_req && !pwrite_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// events; hardware set beats a same-cycle clear
	always_comb
	begin
		ev = '0;
		ev[`TCC_EV_PTD] = state_q != ST_DIALING && state_d == ST_DIALING;
		ev[`TCC_EV_CONNECTED_INDICATOR] = state_q != ST_CONNECTED && state_d == ST_CONNECTED;
		ev[`TCC_EV_IDLE] = state_q != ST_IDLE && state_d == ST_IDLE;
		ev[`TCC_EV_RING] = state_q != ST_RINGING && state_d == ST_RINGING;
		ev[`TCC_EV_DIAL_DONE] = dial_done;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_stat_q <= '0;
			irq_mask_q <= `TCC_IRQ_MASK_RST;
		end
		else
		begin
			if (wr_fire && paddr_i == `TCC_IRQ_STAT_OFF)
				irq_stat_q <= (irq_stat_q & ~pwdata_i[`TCC_EV_W-1:0]) | ev;
			else
				irq_stat_q <= irq_stat_q | ev;
			if (wr_fire && paddr_i == `TCC_IRQ_MASK_OFF)
				irq_mask_q <= pwdata_i[`TCC_EV_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |((irq_stat_q | ev) & irq_mask_q);
	end

	sequence ptd_taken;
		state_q == ST_ORIGINATE && state_d == ST_DIALING;
	endsequence

	sequence ring_over;
		state_q == ST_RINGING && state_d == ST_CONNECTED;
	endsequence

	chk_idle_dark: assert property (state_q == ST_IDLE |-> // RQ3
		!connected_indicator_o && !dial_lamp_o && !local_lamp_o && !buzzer_o && !loop_shunt_o)
	else $error("indicator lit in idle");

	chk_orig_shunt: assert property (state_q == ST_ORIGINATE |-> loop_shunt_o && !dial_lamp_o) // RQ4
	else $error("no shunt while originating");

	chk_ptd_latch: assert property (ptd_taken |-> filt_q[0] >= 8'(PTD_MS) // RQ5
		##1 (dial_lamp_o && loop_shunt_o))
	else $error("proceed to dial not latched");

	chk_break_length: assert property ((dial_busy && !dial_make_q && tick_q // RQ6
		&& dial_ms_q == 8'(BREAK_MS - 1)) |=> dial_make_q && dial_ms_q == 8'h00)
	else $error("dial break length wrong");

	chk_contact_inside: assert property (dial_contact_o |-> loop_open_o) // RQ1
	else $error("contact open outside break");

	chk_connected_indicator_outputs: assert property (state_q == ST_CONNECTED |-> // RQ7
		motor_o && connected_indicator_o && loop_shunt_o)
	else $error("connected outputs wrong");

	chk_connected_indicator_filter: assert property ((state_q inside {ST_DIALING, ST_IDLE} // RQ15
		&& state_d == ST_CONNECTED) |-> filt_q[1] >= 8'(CONNECTED_INDICATOR_MS))
	else $error("connect taken unfiltered");

	chk_return_idle: assert property ((state_q inside {ST_CONNECTED, ST_DISCONNECT} // RQ9
		&& state_d == ST_IDLE) |-> pos_seen ##1 !connected_indicator_o)
	else $error("idle return without positive current");

	chk_incoming: assert property ((state_q == ST_IDLE && state_d == ST_CONNECTED) // RQ10
		|=> loop_shunt_o && motor_o)
	else $error("incoming call not answered");

	chk_stop_open: assert property (state_q == ST_DISCONNECT |-> loop_open_o) // RQ11
	else $error("line not open on stop");

	chk_local_lamp: assert property (state_q == ST_LOCAL |-> local_lamp_o && motor_o) // RQ13
	else $error("local lamp off in local");

	chk_buzz_span: assert property (ring_over |-> buzz_ms_q == 12'(BUZZ_MS) // RQ14
		##1 (connected_indicator_o && !buzzer_o))
	else $error("buzzer interval wrong");

	chk_sel_blind: assert property ((dial_offnormal_i || dial_busy) |=> selector_driver_o) // RQ2
	else $error("selector not blinded");

	chk_sel_follow: assert property ((!dial_offnormal_i && !dial_busy) // RQ16
		|=> selector_driver_o == $past(line_i.mark))
	else $error("selector not following line");

	chk_motor_delay: assert property ($fell(motor_o) |-> off_ms_q == 12'(MOTOR_MS)) // RQ17
	else $error("motor stopped early");

endmodule
`default_nettype wire

//--- telegraph_call_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module telegraph_call_control_tb;
	import tcc_pkg::*;
	localparam int TK = 10;
	localparam int BR = 3;
	localparam int MK = 2;
	localparam int BZ = 5;
	localparam int MO = 4;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, offn = 0;
	logic [7:0] pa = '0;
	logic [31:0] pwd = '0, prd, rd;
	logic prdy, perr, er, shunt, lopen, contact, dlamp, connected_indicator, llamp, buzz, motor, sel, irq;
	logic lopen_prev;
	logic [1:0] cmd = 2'h1;
	line_type line;
	buttons_type btn = '0;
	int n_fail = 0, total_checks = 0, cyc = 0, n, m;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
	row_type rows[3] = '{'{8'h04, 32'h1, 1'b0}, '{8'h0c, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b1}};
	initial forever #50 clk = ~clk;
	tcc_exchange u_ex (.ref_clk_i(clk), .cmd_i(cmd), .shunt_i(shunt), .open_i(lopen),
		.line_o(line));
	telegraph_call_control #(.TICK_CYC(TK), .PTD_MS(1), .CONNECTED_INDICATOR_MS(2), .BREAK_MS(BR),
		.MAKE_MS(MK), .CONTACT_MS(1), .BUZZ_MS(BZ), .MOTOR_MS(MO)) u_dut (
		.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.line_i(line), .buttons_i(btn), .dial_offnormal_i(offn), .loop_shunt_o(shunt),
		.loop_open_o(lopen), .dial_contact_o(contact), .dial_lamp_o(dlamp),
		.connected_indicator_o(connected_indicator), .local_lamp_o(llamp), .buzzer_o(buzz),
		.motor_o(motor), .selector_driver_o(sel), .irq_o(irq));
	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task ms(input int k);
		repeat (k * TK) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk({shunt, motor, connected_indicator, dlamp, llamp, buzz, irq, sel}, 32'h1);
		foreach (rows[i])
		begin
			apb(0, rows[i].a, '0);
			chk(rd, rows[i].d);
			chk(er, rows[i].e);
		end
		btn.originate <= 1;
		wait (shunt === 1'b1);
		cmd <= 2'h0;
		ms(3);
		cmd <= 2'h1;
		wait (dlamp === 1'b1);
		btn.originate <= 0;
		ms(2);
		chk(shunt, 1);
		chk(irq, 0);
		apb(1, 8'h00, 32'hb);
		ms(2);
		chk(lopen, 0);
		// dial off rest blinds the selector while the loop breaks
		offn <= 1;
		apb(1, 8'h00, 32'h2);
		n = 0;
		m = 0;
		lopen_prev = lopen;
		repeat (150)
		begin
			@(posedge clk);
			n += (lopen && !lopen_prev) ? 1 : 0;
			lopen_prev = lopen;
			m += contact;
			chk(sel, 1);
		end
		chk(n, 2);
		chk(m >= TK && m <= 2 * TK, 1);
		offn <= 0;
		apb(1, 8'h0c, 32'h2);
		cmd <= 2'h2;
		wait (connected_indicator === 1'b1);
		@(negedge clk);
		chk({motor, shunt}, 2'h3);
		chk(irq, 1);
		apb(1, 8'h08, 32'h1f);
		// irq is registered from the old status, so it drops a clock after the clear
		repeat (2) @(negedge clk);
		chk(irq, 0);
		cmd <= 2'h0;
		repeat (4) @(posedge clk);
		chk(sel, 0);
		cmd <= 2'h2;
		repeat (4) @(posedge clk);
		chk(sel, 1);
		btn.hangup_button_alt <= 1;
		wait (lopen === 1'b1);
		chk(connected_indicator, 1);
		cmd <= 2'h1;
		wait (connected_indicator === 1'b0);
		btn.hangup_button_alt <= 0;
		ms(3);
		chk(motor, 1);
		ms(3);
		chk(motor, 0);
		apb(0, 8'h04, '0);
		chk(rd, 32'h1);
		cmd <= 2'h2;
		wait (connected_indicator === 1'b1);
		@(negedge clk);
		chk({shunt, motor}, 2'h3);
		cmd <= 2'h0;
		ms(1);
		cmd <= 2'h1;
		wait (connected_indicator === 1'b0);
		ms(6);
		chk({motor, shunt}, 2'h0);
		btn.offline_button_alt <= 1;
		wait (llamp === 1'b1);
		btn.offline_button_alt <= 0;
		cmd <= 2'h2;
		wait (buzz === 1'b1);
		n = 0;
		while (connected_indicator !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk(n >= (BZ - 1) * TK && n <= BZ * TK + 2, 1);
		chk(buzz, 0);
		// local then originate starts a call; releasing too soon drops it
		btn.hangup_button_alt <= 1;
		cmd <= 2'h1;
		wait (connected_indicator === 1'b0);
		btn.hangup_button_alt <= 0;
		@(posedge clk);
		btn.offline_button_alt <= 1;
		wait (llamp === 1'b1);
		btn.offline_button_alt <= 0;
		@(posedge clk);
		btn.originate <= 1;
		wait (shunt === 1'b1);
		@(negedge clk);
		chk({llamp, shunt}, 2'h1);
		@(posedge clk);
		btn.originate <= 0;
		wait (shunt === 1'b0);
		apb(0, 8'h04, '0);
		chk(rd[6:0], 7'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
